// file: verilog/bpd_pkg.sv
package bpd_pkg;
    // register byte offsets
    localparam logic [7:0] BPD_OFF_CCPCON = 8'h00;
    localparam logic [7:0] BPD_OFF_SHDN = 8'h04;
    localparam logic [7:0] BPD_OFF_PWMCON = 8'h08;
    localparam logic [7:0] BPD_OFF_MISC = 8'h0c;
    localparam logic [7:0] BPD_OFF_STAT = 8'h10;
    // capture_compare_control fields
    localparam int BPD_DIR_BIT = 7;
    localparam int BPD_CFG_LO = 6;
    localparam int BPD_MODE_HI = 3;
    localparam int BPD_MODE_LO = 2;
    localparam int BPD_POL_AC = 1;
    localparam int BPD_POL_BD = 0;
    // auto_shutdown_control fields
    localparam int BPD_ASE_BIT = 7;
    localparam int BPD_SRC_HI = 6;
    localparam int BPD_SRC_LO = 4;
    localparam int BPD_SAC_HI = 3;
    localparam int BPD_SAC_LO = 2;
    localparam int BPD_SBD_HI = 1;
    localparam int BPD_SBD_LO = 0;
    // pwm_control_register and misc fields
    localparam int BPD_RST_BIT = 7;
    localparam int BPD_SYNC_BIT = 4;
    localparam int BPD_DRV_HI = 3;
    // reset values and field codes
    localparam logic [7:0] BPD_CCPCON_RST = 8'h00;
    localparam logic [7:0] BPD_SHDN_RST = 8'h00;
    localparam logic [7:0] BPD_PWMCON_RST = 8'h00;
    localparam logic [4:0] BPD_MISC_RST = 5'h00;
    localparam logic [1:0] BPD_MODE_PWM = 2'h3;
    localparam logic [1:0] BPD_SS_LOW = 2'h0;
    localparam logic [1:0] BPD_SS_HIGH = 2'h1;

    typedef enum logic [3:0] {
        BPD_CFG_SINGLE = 4'b0001,
        BPD_CFG_FWD = 4'b0010,
        BPD_CFG_HALF = 4'b0100,
        BPD_CFG_REV = 4'b1000
    } bpd_cfg_t;
endpackage : bpd_pkg

// file: verilog/bpd_bridge.sv
`timescale 1ns/1ps
// How it works
// - full-bridge direction comes from direction bit, applied from next pwm cycle
// - on direction change blank modulated pins, swap unmodulated early, resume next period
// - early swap leads period end by prescale oscillator periods (timer match window)
// - no dead-band in full-bridge; only one output ever modulated
// - pair a/c and pair b/d polarity chosen by polarity field bits 1 and 0
// - period timer flag set as each pwm period begins
// - source select bits 6-4 pick comparator one, two, interrupt pin low combinations
// - software writing one to shutdown status acts as a shutdown event
// - shutdown status set on event, zero normally, held until cleared or restart
// - enabled pins forced to shutdown state asynchronously, no clock needed
// - pair a/c state bits 3-2: 00 low, 01 high, 1x high impedance
// - pair b/d state bits 1-0: 00 low, 01 high, 1x high impedance
// - shutdown is level sensitive, held while any selected source asserted
// - software writes to shutdown status ignored while condition asserted
// - after restart output resumes only at start of next pwm period
// - with auto restart, status held during condition, cleared by hardware after
// - with comparator two sync on, comparator two shutdown waits for timer-one tick
// - auto restart enable is control bit 7; off means software clears status
// - forward: a active, d modulated; reverse: c active, b modulated
module bpd_bridge (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pwm core, same clock
    input wire logic pwm_mod,
    input wire logic timer_match,
    input wire logic t1_tick,
    // shutdown sources, asynchronous
    input wire logic int_pin_n,
    input wire logic comparator_one,
    input wire logic comparator_two,
    // bridge pins
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic period_timer_flag
);
    import bpd_pkg::*;

    logic [7:0] ccp_q;
    logic [7:0] shdn_q;
    logic [7:0] pwmcon_q;
    logic [4:0] misc_q;
    logic [31:0] rdata_q;
    logic rdy_q;
    logic err_q;
    logic flag_q;
    logic match_q;
    logic dir_q;
    logic swap_q;
    logic blank_q;
    logic run_q;
    logic wait_q;
    logic two_lat_q;
    logic [3:0] act_q;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [3:0] act_d;

    // apb decode
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite & rdy_q;
    wire hit_ccp = paddr == BPD_OFF_CCPCON;
    wire hit_shdn = paddr == BPD_OFF_SHDN;
    wire hit_pwm = paddr == BPD_OFF_PWMCON;
    wire hit_misc = paddr == BPD_OFF_MISC;
    wire hit_stat = paddr == BPD_OFF_STAT;
    wire mapped = hit_ccp | hit_shdn | hit_pwm | hit_misc | hit_stat;
    wire [31:0] rmux = hit_ccp ? {24'h000000, ccp_q} :
                       hit_shdn ? {24'h000000, shdn_q} :
                       hit_pwm ? {24'h000000, pwmcon_q} :
                       hit_misc ? {27'h0, misc_q} :
                       hit_stat ? {31'h0, flag_q} : 32'h00000000;

    // period boundary: match window is the last timer count, prescale clocks long
    wire period_start = match_q & ~timer_match;
    wire early = timer_match & ~match_q;

    // configuration decode
    wire [1:0] cfg_raw = {ccp_q[BPD_DIR_BIT], ccp_q[BPD_CFG_LO]};
    wire pwm_on = ccp_q[BPD_MODE_HI:BPD_MODE_LO] == BPD_MODE_PWM;
    wire full = ccp_q[BPD_CFG_LO];
    wire new_dir = ccp_q[BPD_DIR_BIT];
    wire pend = full & (new_dir != dir_q);
    wire [1:0] cfg_eff = full ? {dir_q, 1'b1} : cfg_raw;
    wire bpd_cfg_t cfg = bpd_cfg_t'(4'b0001 << cfg_eff);
    wire unmod_dir = swap_q ? new_dir : dir_q;
    wire [3:0] pol = {ccp_q[BPD_POL_BD], ccp_q[BPD_POL_AC],
                      ccp_q[BPD_POL_BD], ccp_q[BPD_POL_AC]};

    // shutdown sources; comparator two optionally waits for timer-one tick
    wire two_eff = misc_q[BPD_SYNC_BIT] ? two_lat_q : comparator_two;
    wire [2:0] sel = shdn_q[BPD_SRC_HI:BPD_SRC_LO];
    wire src_async = (sel[0] & comparator_one) | (sel[1] & two_eff)
                   | (sel[2] & ~int_pin_n);
    wire two_sync = misc_q[BPD_SYNC_BIT] ? two_lat_q : s2_q[1];
    wire src_sync = (sel[0] & s2_q[0]) | (sel[1] & two_sync)
                  | (sel[2] & ~s2_q[2]);
    wire ase = shdn_q[BPD_ASE_BIT];
    wire sw_set = wr & hit_shdn & pwdata[BPD_ASE_BIT];
    wire sw_clr = wr & hit_shdn & ~pwdata[BPD_ASE_BIT] & ~src_sync;
    wire auto_clr = pwmcon_q[BPD_RST_BIT] & ~src_sync;
    wire ase_d = src_sync | sw_set | (ase & ~sw_clr & ~auto_clr);
    // raw source forces pins with no clock edge involved
    wire force_sd = src_async | ase | wait_q;
    wire [1:0] sac = shdn_q[BPD_SAC_HI:BPD_SAC_LO];
    wire [1:0] sbd = shdn_q[BPD_SBD_HI:BPD_SBD_LO];
    wire [3:0] sd_val = {sbd == BPD_SS_HIGH, sac == BPD_SS_HIGH,
                         sbd == BPD_SS_HIGH, sac == BPD_SS_HIGH};
    wire [3:0] sd_hiz = {sbd[1], sac[1], sbd[1], sac[1]};
    wire [3:0] drv = misc_q[BPD_DRV_HI:0];
    wire [3:0] pin_reg = act_q ^ pol;

    // combinational override is the price of an asynchronous shutdown
    assign pin_out = force_sd ? sd_val : pin_reg;
    assign pin_oe = force_sd ? (drv & ~sd_hiz) : drv;
    assign prdata = rdata_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    assign period_timer_flag = flag_q;

    // active-level pattern, index {d,c,b,a}
    always_comb
    begin
        act_d = 4'h0;
        case (cfg)
            BPD_CFG_SINGLE: act_d = {3'h0, pwm_mod};
            BPD_CFG_HALF: act_d = {2'h0, ~pwm_mod, pwm_mod};
            BPD_CFG_FWD, BPD_CFG_REV:
            begin
                // one modulated pin only, so no dead-band is inserted
                act_d[0] = ~unmod_dir;
                act_d[2] = unmod_dir;
                act_d[3] = ~dir_q & pwm_mod & ~blank_q;
                act_d[1] = dir_q & pwm_mod & ~blank_q;
            end
            default: act_d = 4'h0;
        endcase
        if (!run_q)
        begin
            act_d = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rdy_q <= setup;
            err_q <= setup & ~mapped;
            rdata_q <= setup ? rmux : rdata_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ccp_q <= BPD_CCPCON_RST;
            pwmcon_q <= BPD_PWMCON_RST;
            misc_q <= BPD_MISC_RST;
            shdn_q <= BPD_SHDN_RST;
        end
        else
        begin
            ccp_q <= (wr & hit_ccp) ? pwdata[7:0] : ccp_q;
            pwmcon_q <= (wr & hit_pwm) ? pwdata[7:0] : pwmcon_q;
            misc_q <= (wr & hit_misc) ? pwdata[4:0] : misc_q;
            shdn_q[6:0] <= (wr & hit_shdn) ? pwdata[6:0] : shdn_q[6:0];
            shdn_q[BPD_ASE_BIT] <= ase_d;
        end
    end

    // synchronisers: stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 3'h4;
            s2_q <= 3'h4;
            two_lat_q <= 1'b0;
        end
        else
        begin
            s1_q <= {int_pin_n, comparator_two, comparator_one};
            s2_q <= s1_q;
            two_lat_q <= t1_tick ? s2_q[1] : two_lat_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_q <= 1'b0;
            flag_q <= 1'b0;
            dir_q <= 1'b0;
            swap_q <= 1'b0;
            blank_q <= 1'b0;
            run_q <= 1'b0;
            wait_q <= 1'b0;
            act_q <= 4'h0;
        end
        else
        begin
            match_q <= timer_match;
            // set beats a same-cycle clear
            flag_q <= period_start | (flag_q & ~(wr & hit_stat & pwdata[0]));
            dir_q <= period_start ? new_dir : dir_q;
            swap_q <= ~period_start & (swap_q | (pend & (early | timer_match)));
            blank_q <= ~period_start & (blank_q | (pend & (early | timer_match)));
            run_q <= pwm_on & (run_q | period_start);
            wait_q <= ase_d | (wait_q & ~period_start);
            act_q <= act_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_flag_set;
        period_start |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_dir_hold;
        !period_start |=> $stable(dir_q);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved mid period");

    property p_blank;
        blank_q && full |-> !act_d[1] && !act_d[3];
    endproperty
    a_blank: assert property (p_blank) else $error("modulated pin not blanked");

    property p_early;
        pend && early |=> swap_q && blank_q;
    endproperty
    a_early: assert property (p_early) else $error("early swap missed");

    property p_one_mod;
        full |-> !(act_d[1] && act_d[3]);
    endproperty
    a_one_mod: assert property (p_one_mod) else $error("two modulated pins");

    property p_force;
        src_async && drv[0] && !sac[1] |-> pin_oe[0] && pin_out[0] == sac[0];
    endproperty
    a_force: assert property (p_force) else $error("pin a not forced");

    property p_hiz;
        force_sd && sbd[1] |-> pin_oe[1] == 1'b0 && pin_oe[3] == 1'b0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pair bd not released");

    property p_level;
        src_sync |=> ase;
    endproperty
    a_level: assert property (p_level) else $error("status dropped while active");

    property p_auto;
        ase && pwmcon_q[BPD_RST_BIT] && !src_sync && !sw_set |=> !ase;
    endproperty
    a_auto: assert property (p_auto) else $error("auto restart missed");

    property p_resume;
        ase && !period_start ##1 !ase && !period_start |-> wait_q;
    endproperty
    a_resume: assert property (p_resume) else $error("resumed before period");

    property p_sw_set;
        sw_set |=> ase;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software event not taken");

    property p_sw_ignore;
        wr && hit_shdn && src_sync |=> ase;
    endproperty
    a_sw_ignore: assert property (p_sw_ignore) else $error("status cleared during event");

    property p_hold_manual;
        ase && !pwmcon_q[BPD_RST_BIT] && !(wr && hit_shdn) |=> ase;
    endproperty
    a_hold_manual: assert property (p_hold_manual) else $error("status left on its own");

    property p_hiz_ac;
        force_sd && sac[1] |-> !pin_oe[0] && !pin_oe[2];
    endproperty
    a_hiz_ac: assert property (p_hiz_ac) else $error("pair ac not released");

    property p_drive_bd;
        force_sd && !sbd[1] |-> pin_oe[1] == drv[1] && pin_out[1] == sbd[0] && pin_out[3] == sbd[0];
    endproperty
    a_drive_bd: assert property (p_drive_bd) else $error("pair bd level wrong");

    property p_dir_take;
        period_start |=> dir_q == $past(new_dir);
    endproperty
    a_dir_take: assert property (p_dir_take) else $error("direction not taken");

    property p_fwd;
        run_q && full && !dir_q && !swap_q |=> act_q[0] && !act_q[1] && !act_q[2];
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward pattern wrong");

    property p_rev;
        run_q && full && dir_q && !swap_q |=> act_q[2] && !act_q[0] && !act_q[3];
    endproperty
    a_rev: assert property (p_rev) else $error("reverse pattern wrong");

    property p_sync_delay;
        !t1_tick |=> $stable(two_lat_q);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("latch moved off tick");

    property p_int_src;
        sel[2] && !int_pin_n |-> force_sd;
    endproperty
    a_int_src: assert property (p_int_src) else $error("pin source not forcing");

    property p_wait_release;
        period_start && !ase_d |=> !wait_q;
    endproperty
    a_wait_release: assert property (p_wait_release) else $error("restart not released");

    property p_swap_end;
        period_start |=> !swap_q && !blank_q;
    endproperty
    a_swap_end: assert property (p_swap_end) else $error("blanking kept past period");

    property p_blank_pin;
        blank_q && full |=> !act_q[1] && !act_q[3];
    endproperty
    a_blank_pin: assert property (p_blank_pin) else $error("modulated pin active");
endmodule : bpd_bridge

// file: testbench/bpd_drv_model.sv
`timescale 1ns/1ps
module bpd_drv_model (
    // pins from the block
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // gate level seen by each switch driver
    output logic [3:0] gate
);
    // board pull-downs hold a floating gate off, so an undriven pin reads 0
    assign gate = pin_out & pin_oe;
endmodule : bpd_drv_model

// file: testbench/bpd_bridge_tb.sv
`timescale 1ns/1ps
module bpd_bridge_tb;
    import bpd_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, period_timer_flag;
    logic pwm_mod = 1'h0, mod_prev = 1'h0, timer_match = 1'h0, t1_tick = 1'h0;
    logic int_pin_n = 1'h1, comparator_one = 1'h0, comparator_two = 1'h0;
    logic [3:0] pin_out, pin_oe, gate;
    logic [4:0] cnt = 5'h0;
    logic [4:0] duty = 5'h1;
    logic [32:0] rdq[$];
    logic [32:0] note;
    logic [1:0] ac, bd;
    int fails = 0, checks = 0, cyc = 0;

    always #25 pclk = ~pclk;

    bpd_bridge dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pwm_mod, .timer_match, .t1_tick, .int_pin_n,
        .comparator_one, .comparator_two, .pin_out, .pin_oe, .period_timer_flag);
    bpd_drv_model drv_u (.pin_out, .pin_oe, .gate);

    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // period of 20 clocks, match high for the last 5
    always @(posedge pclk)
    begin
        cnt <= (cnt == 5'h13) ? 5'h0 : cnt + 5'h1;
        timer_match <= (cnt >= 5'he) && (cnt != 5'h13);
        // duty stays well below full, so reversal needs no extra step
        if (cnt == 5'h13)
            duty <= 5'($urandom % 14) + 5'h1;
        pwm_mod <= cnt < duty;
        mod_prev <= pwm_mod;
        t1_tick <= cnt[1:0] == 2'h0;
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            fails++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end

    // read results compared in bus order
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && rdq.size() > 0)
        begin
            note = rdq.pop_front();
            checks++;
            if ({pslverr, prdata} !== note)
            begin
                fails++;
                $display("[ERR] %0t read %h exp %h", $time, {pslverr, prdata}, note);
            end
        end

    // idle edge first, so psel never gets two values in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk iff pready);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask : wr

    task rd(input logic [7:0] a, input logic [8:0] e);
        rdq.push_back({e[8], 24'h0, e[7:0]});
        apb(1'h0, a, 32'h0);
    endtask : rd

    task cmp(input logic [7:0] e);
        checks++;
        if ({pin_oe, gate} !== e)
        begin
            fails++;
            $display("[ERR] %0t pins %h exp %h", $time, {pin_oe, gate}, e);
        end
    endtask : cmp

    task chk(input logic [7:0] e);
        @(negedge pclk);
        cmp(e);
    endtask : chk

    task flg(input logic e);
        @(negedge pclk);
        checks++;
        if (period_timer_flag !== e)
        begin
            fails++;
            $display("[ERR] %0t flag %b exp %b", $time, period_timer_flag, e);
        end
    endtask : flg

    // running bridge: one modulated pin, one held active
    task run(input logic rev, input logic pol);
        @(negedge pclk);
        cmp({4'hf, (rev ? {2'h1, mod_prev, 1'h0} : {mod_prev, 3'h1}) ^ {4{pol}}});
    endtask : run

    task ws;
        @(posedge pclk iff cnt == 5'h4);
    endtask : ws

    task done(input string n);
        $display("%0t test %s done", $time, n);
    endtask : done

    function automatic logic [7:0] sdx(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] o, g;
        o = {~b[1], ~a[1]};
        g = {b == 2'h1, a == 2'h1};
        return {o, o, g, g};
    endfunction : sdx

    initial
    begin
        void'($urandom(62));
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rd(BPD_OFF_CCPCON, 9'h000);
        rd(BPD_OFF_SHDN, 9'h000);
        rd(BPD_OFF_PWMCON, 9'h000);
        rd(8'h14, 9'h100);
        done("registers");
        wr(BPD_OFF_CCPCON, 8'h4c);
        ws();
        wr(BPD_OFF_STAT, 8'h01);
        rd(BPD_OFF_STAT, 9'h000);
        flg(1'h0);
        ws();
        rd(BPD_OFF_STAT, 9'h001);
        flg(1'h1);
        wr(BPD_OFF_MISC, 8'h0f);
        ws();
        run(1'h0, 1'h0);
        done("start");
        wr(BPD_OFF_CCPCON, 8'hcc);
        run(1'h0, 1'h0);
        @(posedge pclk iff cnt == 5'h11);
        chk(8'hf4);
        ws();
        run(1'h1, 1'h0);
        wr(BPD_OFF_MISC, 8'h00);
        wr(BPD_OFF_CCPCON, 8'hcf);
        wr(BPD_OFF_MISC, 8'h0f);
        ws();
        run(1'h1, 1'h1);
        done("direction");
        for (int s = 1; s < 8; s++)
        begin
            ac = 2'((s + 2) % 3);
            bd = 2'(s % 3);
            wr(BPD_OFF_SHDN, {1'h0, 3'(s), ac, bd});
            comparator_one <= s[0];
            comparator_two <= s[1] & ~s[0];
            int_pin_n <= (s != 4);
            chk(sdx(ac, bd));
            repeat (4) @(posedge pclk);
            rd(BPD_OFF_SHDN, {1'h0, 1'h1, 3'(s), ac, bd});
            wr(BPD_OFF_SHDN, {1'h0, 3'(s), ac, bd});
            rd(BPD_OFF_SHDN, {1'h0, 1'h1, 3'(s), ac, bd});
            chk(sdx(ac, bd));
            @(posedge pclk);
            comparator_one <= 1'h0;
            comparator_two <= 1'h0;
            int_pin_n <= 1'h1;
            repeat (4) @(posedge pclk);
            @(posedge pclk iff cnt == 5'h6);
            wr(BPD_OFF_SHDN, {1'h0, 3'(s), ac, bd});
            chk(sdx(ac, bd));
            ws();
            run(1'h1, 1'h1);
        end
        done("shutdown");
        wr(BPD_OFF_SHDN, 8'h81);
        chk(8'hfa);
        rd(BPD_OFF_SHDN, 9'h081);
        wr(BPD_OFF_SHDN, 8'h01);
        ws();
        run(1'h1, 1'h1);
        done("firmware");
        wr(BPD_OFF_PWMCON, 8'h80);
        wr(BPD_OFF_SHDN, 8'h10);
        comparator_one <= 1'h1;
        repeat (4) @(posedge pclk);
        rd(BPD_OFF_SHDN, 9'h090);
        @(posedge pclk iff cnt == 5'h6);
        comparator_one <= 1'h0;
        repeat (5) @(posedge pclk);
        rd(BPD_OFF_SHDN, 9'h010);
        rd(BPD_OFF_PWMCON, 9'h080);
        ws();
        run(1'h1, 1'h1);
        done("restart");
        wr(BPD_OFF_MISC, 8'h1f);
        wr(BPD_OFF_SHDN, 8'h20);
        comparator_two <= 1'h1;
        run(1'h1, 1'h1);
        repeat (8) @(posedge pclk);
        rd(BPD_OFF_SHDN, 9'h0a0);
        comparator_two <= 1'h0;
        ws();
        ws();
        rd(BPD_OFF_SHDN, 9'h020);
        run(1'h1, 1'h1);
        done("sync");
        print_verdict();
    end
endmodule : bpd_bridge_tb
